// [hw/fpb_top.sv]
// Fan PWM frequency select, source binding, ramp and max-duty arbitration
`timescale 1ns/1ns
`include "fpb_regs.svh"

// One PWM channel: prescaler per code, 8-bit phase compare
module fpb_pwm_chan (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire fpb_pkg::fpb_freq_t freq_code,
    input  wire fpb_pkg::fpb_duty_t duty,
    output logic                   pwm_ff
);
    logic [15:0]        div_ff,   nxt_div;    // Prescaler count
    logic [7:0]         phase_ff, nxt_phase;  // Phase in the period
    fpb_pkg::fpb_duty_t duty_ff,  nxt_duty;   // Duty held for the period
    logic               nxt_pwm;
    logic [15:0]        div_end;              // Last prescaler count

    // Divider per code
    // frequency code decode
    always_comb begin
        case (freq_code)
            3'h0:    div_end = 16'(`FPB_DIV(`FPB_F0_HZ) - 1);
            3'h1:    div_end = 16'(`FPB_DIV(`FPB_F1_HZ) - 1);
            3'h2:    div_end = 16'(`FPB_DIV(`FPB_F2_HZ) - 1);
            3'h3:    div_end = 16'(`FPB_DIV(`FPB_F3_HZ) - 1);
            3'h4:    div_end = 16'(`FPB_DIV(`FPB_F4_HZ) - 1);
            3'h5:    div_end = 16'(`FPB_DIV(`FPB_F5_HZ) - 1);
            3'h6:    div_end = 16'(`FPB_DIV(`FPB_F6_HZ) - 1);
            default: div_end = 16'(`FPB_DIV(`FPB_F7_HZ) - 1);
        endcase
    end

    // Next state; duty only changes at period start to avoid runt pulses
    always_comb begin
        nxt_div   = div_ff;
        nxt_phase = phase_ff;
        nxt_duty  = duty_ff;
        if (div_ff >= div_end) begin
            // A shorter divider after a code change wraps here at once
            nxt_div   = 16'h0000;
            nxt_phase = phase_ff + 8'h01;
            if (phase_ff == 8'hff) begin
                nxt_duty = duty;
            end
        end else begin
            nxt_div = div_ff + 16'h0001;
        end
        // Full duty stays high with no gap
        nxt_pwm = (duty_ff == `FPB_DUTY_FULL) || (phase_ff < duty_ff);
    end

    // Registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_ff   <= 16'h0000;
            phase_ff <= 8'h00;
            duty_ff  <= `FPB_DUTY_OFF;
            pwm_ff   <= 1'b0;
        end else begin
            div_ff   <= nxt_div;
            phase_ff <= nxt_phase;
            duty_ff  <= nxt_duty;
            pwm_ff   <= nxt_pwm;
        end
    end

    AST_PWM_FULL_HIGH: assert property (@(posedge clk) disable iff (rst)
        duty_ff == `FPB_DUTY_FULL |=> pwm_ff)
        else $error("Full duty did not hold output high");
    AST_PWM_OFF_LOW: assert property (@(posedge clk) disable iff (rst)
        duty_ff == `FPB_DUTY_OFF |=> !pwm_ff)
        else $error("Zero duty let output go high");
endmodule

// One ramp source: climbs while hot, falls while cool, one step per tick
module fpb_ramp (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               hot,
    input  wire logic               tick,
    output fpb_pkg::fpb_duty_t      duty_ff
);
    fpb_pkg::fpb_duty_t nxt_duty;

    always_comb begin
        nxt_duty = duty_ff;
        if (tick) begin
            if (hot && duty_ff != `FPB_DUTY_FULL) begin
                nxt_duty = duty_ff + `FPB_RAMP_STEP;
            end else if (!hot && duty_ff != `FPB_DUTY_OFF) begin
                nxt_duty = duty_ff - `FPB_RAMP_STEP;
            end
        end
    end

    // Register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            duty_ff <= `FPB_DUTY_OFF;
        end else begin
            duty_ff <= nxt_duty;
        end
    end

    // hot tick raises duty by one step
    AST_RAMP_UP: assert property (@(posedge clk) disable iff (rst)
        tick && hot && duty_ff != `FPB_DUTY_FULL
        |=> duty_ff == $past(duty_ff) + `FPB_RAMP_STEP)
        else $error("Ramp did not step up");
    AST_RAMP_HOLD: assert property (@(posedge clk) disable iff (rst)
        !tick |=> $stable(duty_ff))
        else $error("Ramp moved between ticks");
endmodule

// Top: byte registers, input sync, ramps, arbitration, two PWM outputs
module fpb_top #(
    parameter int RAMP_TICK_CYC = `FPB_RAMP_CYC
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire fpb_pkg::fpb_req_s      reg_req,
    output logic [7:0]                  reg_rdata_ff,
    input  wire fpb_pkg::fpb_hot_s      hot_pins,
    input  wire logic [3:0][7:0]        zone_duty_in,
    input  wire fpb_pkg::fpb_duty_t     pwm_a_duty,
    input  wire fpb_pkg::fpb_freq_t     pwm_b_freq_code,
    output fpb_pkg::fpb_duty_t          pwm_b_duty_ff,
    output logic                        fan_pwm_out_a,
    output logic                        fan_pwm_out_b
);
    fpb_pkg::fpb_freq_t  pwm_a_freq_code_ff, nxt_freq;  // Frequency register
    fpb_pkg::fpb_bind_s  bind_ff, nxt_bind;             // Binding register
    logic [7:0]          nxt_rdata;
    fpb_pkg::fpb_hot_s   hot_meta_ff, hot_sync_ff;      // Two-stage sync
    logic [31:0]         tick_cnt_ff, nxt_tick_cnt;     // Ramp interval count
    logic                tick_ff, nxt_tick;             // Ramp step pulse
    logic [3:0][7:0]     ramp_duty;                     // Per-source ramp duty
    logic [7:0][7:0]     req_duty;                      // All requests, bind order
    fpb_pkg::fpb_duty_t  nxt_duty_b;

    // Register writes and reads
    always_comb begin
        nxt_freq  = pwm_a_freq_code_ff;
        nxt_bind  = bind_ff;
        nxt_rdata = reg_rdata_ff;
        if (reg_req.wr) begin
            case (reg_req.addr)
                `FPB_ADDR_FREQ_A: nxt_freq = reg_req.wdata[`FPB_FREQ_MSB:0];
                `FPB_ADDR_BIND_B: nxt_bind = reg_req.wdata;
                default:          nxt_bind = bind_ff;
            endcase
        end
        if (reg_req.rd) begin
            case (reg_req.addr)
                `FPB_ADDR_FREQ_A: nxt_rdata = {`FPB_FREQ_PAD, pwm_a_freq_code_ff};
                `FPB_ADDR_BIND_B: nxt_rdata = bind_ff;
                default:          nxt_rdata = `FPB_RD_UNMAPPED;
            endcase
        end
    end

    // Register bank
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwm_a_freq_code_ff <= `FPB_RST_FREQ_A;
            bind_ff            <= `FPB_RST_BIND_B;
            reg_rdata_ff       <= `FPB_RD_UNMAPPED;
        end else begin
            pwm_a_freq_code_ff <= nxt_freq;
            bind_ff            <= nxt_bind;
            reg_rdata_ff       <= nxt_rdata;
        end
    end

    // Pin inputs cross two flip-flops before any logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hot_meta_ff <= '0;
            hot_sync_ff <= '0;
        end else begin
            hot_meta_ff <= hot_pins;
            hot_sync_ff <= hot_meta_ff;
        end
    end

    // Ramp interval timer, one pulse per interval
    always_comb begin
        nxt_tick     = 1'b0;
        nxt_tick_cnt = tick_cnt_ff + 32'h1;
        if (tick_cnt_ff >= 32'(RAMP_TICK_CYC - 1)) begin
            nxt_tick_cnt = 32'h0;
            nxt_tick     = 1'b1;
        end
    end

    // Timer registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_ff <= 32'h0;
            tick_ff     <= 1'b0;
        end else begin
            tick_cnt_ff <= nxt_tick_cnt;
            tick_ff     <= nxt_tick;
        end
    end

    // One ramp per hot input
    // hot inputs feed ramps
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ramp
            fpb_ramp u_ramp (
                .clk     (clk),
                .rst     (rst),
                .hot     (hot_sync_ff[gi]),
                .tick    (tick_ff),
                .duty_ff (ramp_duty[gi])
            );
        end
    endgenerate

    // zone lookup results used as is
    assign req_duty = {ramp_duty, zone_duty_in};

    // Largest bound request; unbound sources count as zero
    // max over bound sources
    always_comb begin
        nxt_duty_b = `FPB_DUTY_OFF;
        for (int i = 0; i < 8; i++) begin
            if (bind_ff[i] && req_duty[i] > nxt_duty_b) begin
                nxt_duty_b = req_duty[i];
            end
        end
    end

    // Arbitrated duty register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwm_b_duty_ff <= `FPB_DUTY_OFF;
        end else begin
            pwm_b_duty_ff <= nxt_duty_b;
        end
    end

    // Channel A: frequency from register
    fpb_pwm_chan u_pwm_a (
        .clk       (clk),
        .rst       (rst),
        .freq_code (pwm_a_freq_code_ff),
        .duty      (pwm_a_duty),
        .pwm_ff    (fan_pwm_out_a)
    );

    // Channel B: same encoding, arbitrated duty
    fpb_pwm_chan u_pwm_b (
        .clk       (clk),
        .rst       (rst),
        .freq_code (pwm_b_freq_code),
        .duty      (pwm_b_duty_ff),
        .pwm_ff    (fan_pwm_out_b)
    );

    // Write then read of the frequency register
    sequence s_freq_wr;
        reg_req.wr && !reg_req.rd && reg_req.addr == `FPB_ADDR_FREQ_A;
    endsequence
    sequence s_freq_rd;
        reg_req.rd && !reg_req.wr && reg_req.addr == `FPB_ADDR_FREQ_A;
    endsequence

    AST_FREQ_WR_RD: assert property (@(posedge clk) disable iff (rst)
        s_freq_wr ##1 s_freq_rd |=> reg_rdata_ff[2:0] == $past(reg_req.wdata[2:0], 2))
        else $error("Frequency code did not read back");
    AST_FREQ_RES_ZERO: assert property (@(posedge clk) disable iff (rst)
        s_freq_rd |=> reg_rdata_ff[7:3] == 5'h00)
        else $error("Reserved frequency bits not zero");
    AST_ZONE_ONLY: assert property (@(posedge clk) disable iff (rst)
        bind_ff == 8'h01 |=> pwm_b_duty_ff == $past(zone_duty_in[0]))
        else $error("Zone one binding not followed");
    AST_CPU_ONLY: assert property (@(posedge clk) disable iff (rst)
        bind_ff == 8'h20 |=> pwm_b_duty_ff == $past(ramp_duty[1]))
        else $error("Throttle two binding not followed");
    AST_VR_ONLY: assert property (@(posedge clk) disable iff (rst)
        bind_ff == 8'h40 |=> pwm_b_duty_ff == $past(ramp_duty[2]))
        else $error("Regulator one binding not followed");
    // output never below a bound request
    AST_MAX_WINS: assert property (@(posedge clk) disable iff (rst)
        bind_ff[3] && bind_ff[7] |=>
        pwm_b_duty_ff >= $past(zone_duty_in[3]) && pwm_b_duty_ff >= $past(ramp_duty[3]))
        else $error("Arbitrated duty below a bound request");
    AST_UNBOUND_OFF: assert property (@(posedge clk) disable iff (rst)
        bind_ff == 8'h00 |=> pwm_b_duty_ff == `FPB_DUTY_OFF)
        else $error("Duty nonzero with nothing bound");
endmodule

// [common/fpb_regs.svh]
// Register offsets, reset values and timing counts for the fan PWM source block
`ifndef FPB_REGS_SVH
`define FPB_REGS_SVH

// Register offsets on the byte register port
`define FPB_ADDR_FREQ_A   8'hcb
`define FPB_ADDR_BIND_B   8'hcc
// Reset values
`define FPB_RST_FREQ_A    3'h0
`define FPB_RST_BIND_B    8'h0f
// Field layout of the frequency register
`define FPB_FREQ_MSB      2
`define FPB_FREQ_PAD      5'h00
`define FPB_RD_UNMAPPED   8'h00
// System clock rate
`define FPB_CLK_HZ        50000000
// PWM output frequencies per code, in Hz
`define FPB_F0_HZ         22500
`define FPB_F1_HZ         96
`define FPB_F2_HZ         84
`define FPB_F3_HZ         72
`define FPB_F4_HZ         60
`define FPB_F5_HZ         48
`define FPB_F6_HZ         36
`define FPB_F7_HZ         12
// Steps of duty within one PWM period
`define FPB_STEPS         256
// Prescaler cycles per duty step, derived from the rate
`define FPB_DIV(f)        (`FPB_CLK_HZ / ((f) * `FPB_STEPS))
// Ramp step interval in microseconds and its cycle count
`define FPB_RAMP_US       1000
`define FPB_RAMP_CYC      (`FPB_CLK_HZ / 1000000 * `FPB_RAMP_US)
// Duty limits and ramp increment
`define FPB_DUTY_FULL     8'hff
`define FPB_DUTY_OFF      8'h00
`define FPB_RAMP_STEP     8'h01

`endif

// [common/fpb_pkg.sv]
// Types shared by the fan PWM source block
package fpb_pkg;
    // Frequency select code
    typedef logic [2:0] fpb_freq_t;
    // Duty cycle value, 0 off, ff full on
    typedef logic [7:0] fpb_duty_t;
    // Binding register layout, bit 7 down to bit 0
    typedef struct packed {
        logic bind_regulator_hot_two;
        logic bind_regulator_hot_one;
        logic bind_cpu_throttle_two;
        logic bind_cpu_throttle_one;
        logic bind_zone_four;
        logic bind_zone_three;
        logic bind_zone_two;
        logic bind_zone_one;
    } fpb_bind_s;
    // Hot input group, order matches the binding bits 7:4
    typedef struct packed {
        logic regulator_two_overheat_in;
        logic regulator_one_overheat_in;
        logic cpu_two_throttle_in;
        logic cpu_one_throttle_in;
    } fpb_hot_s;
    // Register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fpb_req_s;
endpackage

// [sim/fpb_fan_model.sv]
// Fan load model: measures period and high time of one PWM drive line
`timescale 1ns/1ns

// Passive fan, it only watches the drive line it is given
module fpb_fan_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        pwm,
    output logic [31:0]      period_ff,
    output logic [31:0]      high_ff,
    output logic [31:0]      width_ff
);
    logic        pwm_ff;   // Previous sample, for rise detection
    logic [31:0] cnt_ff;   // Cycles since last rise
    logic [31:0] hcnt_ff;  // High cycles since last rise

    // Latch counts on each rising drive edge; first result is partial
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwm_ff    <= 1'b0;
            cnt_ff    <= 32'h0;
            hcnt_ff   <= 32'h0;
            period_ff <= 32'h0;
            high_ff   <= 32'h0;
            width_ff  <= 32'h0;
        end else begin
            pwm_ff <= pwm;
            // Fall latches the high run at once, slow codes need no full period
            if (!pwm && pwm_ff) begin
                width_ff <= hcnt_ff;
            end
            if (pwm && !pwm_ff) begin
                period_ff <= cnt_ff;
                high_ff   <= hcnt_ff;
                cnt_ff    <= 32'h1;
                hcnt_ff   <= 32'h1;
            end else begin
                cnt_ff  <= cnt_ff + 32'h1;
                hcnt_ff <= hcnt_ff + {31'h0, pwm};
            end
        end
    end
endmodule

// [sim/tb_fpb_top.sv]
// Self-checking bench for the fan PWM source block
`timescale 1ns/1ns

module tb_fpb_top;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rexp;
    } fpb_row_s;

    logic                 clk = 1'b0;    // 50 MHz
    logic                 rst = 1'b1;    // Async, active high
    fpb_pkg::fpb_req_s    req = '0;      // Register request
    fpb_pkg::fpb_hot_s    hot = '0;      // Hot pins
    logic [3:0][7:0]      zd = '0;       // Zone duty requests
    fpb_pkg::fpb_duty_t   duty_a = 8'h00;
    fpb_pkg::fpb_freq_t   freq_b = 3'h0; // Starts at fastest code
    logic [7:0]           rdata;
    fpb_pkg::fpb_duty_t   duty_b;
    logic                 out_a;
    logic                 out_b;
    logic [31:0]          per_a;
    logic [31:0]          hi_a;
    logic [31:0]          per_b;
    logic [31:0]          hi_b;
    logic [31:0]          wid_a;         // High run of channel A
    logic [31:0]          wid_b;         // High run of channel B
    int                   fails = 0;
    int                   n_checks = 0;
    int                   cyc = 0;
    // Register rows: write, read back, expected byte
    fpb_row_s rows [9] = '{'{8'hcb, 8'hff, 8'h07}, '{8'hcb, 8'h0a, 8'h02},
        '{8'hcb, 8'h05, 8'h05}, '{8'hcc, 8'ha5, 8'ha5}, '{8'hcc, 8'h5a, 8'h5a},
        '{8'h10, 8'h55, 8'h00}, '{8'hcd, 8'h33, 8'h00}, '{8'hcc, 8'h00, 8'h00},
        '{8'hcb, 8'h00, 8'h00}};

    fpb_top #(.RAMP_TICK_CYC(4)) i_fpb_top (.clk(clk), .rst(rst), .reg_req(req),
        .reg_rdata_ff(rdata), .hot_pins(hot), .zone_duty_in(zd), .pwm_a_duty(duty_a),
        .pwm_b_freq_code(freq_b), .pwm_b_duty_ff(duty_b), .fan_pwm_out_a(out_a),
        .fan_pwm_out_b(out_b));
    fpb_fan_model i_fpb_fan_model_a (.clk(clk), .rst(rst), .pwm(out_a),
        .period_ff(per_a), .high_ff(hi_a), .width_ff(wid_a));
    fpb_fan_model i_fpb_fan_model_b (.clk(clk), .rst(rst), .pwm(out_b),
        .period_ff(per_b), .high_ff(hi_b), .width_ff(wid_b));

    always #10 clk = ~clk;

    // Hang guard, tests need about 33000 cycles
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            fails = fails + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (fails == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t count got %0d exp %0d", $time, got, exp);
        end
    endtask

    // One-cycle write pulse
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk) req <= '0;
    endtask

    // Read pulse; data lands on the edge that takes it
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk) req <= '0;
        #1 d = rdata;
    endtask

    // Largest request among bound sources, bits 7:4 are ramps
    function automatic logic [7:0] exp_max(input logic [7:0] b,
                                           input logic [7:0][7:0] q);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (b[i] && q[i] > m) begin
                m = q[i];
            end
        end
        return m;
    endfunction

    // Bind, let arbitration settle, compare with ramp levels rv
    task automatic chk_bind(input logic [7:0] b, input logic [3:0][7:0] rv);
        reg_wr(8'hcc, b);
        repeat (3) @(posedge clk);
        #1 cmp8(duty_b, exp_max(b, {rv, zd}));
    endtask

    // Walk every single bind bit, then some mixes
    task automatic walk_binds(input logic [3:0][7:0] rv);
        for (int i = 0; i < 8; i++) begin
            chk_bind(8'h01 << i, rv);
        end
        chk_bind(8'hff, rv);
        chk_bind(8'h0a, rv);
        chk_bind(8'h00, rv);
    endtask

    initial begin
        logic [7:0] d;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1 cmp8(rdata, 8'h00);
        cmp8(duty_b, 8'h00);
        reg_rd(8'hcb, d);
        cmp8(d, 8'h00);
        reg_rd(8'hcc, d);
        cmp8(d, 8'h0f);
        // Ordinary register rows
        foreach (rows[k]) begin
            reg_wr(rows[k].addr, rows[k].wdata);
            reg_rd(rows[k].addr, d);
            cmp8(d, rows[k].rexp);
        end
        // Back-to-back write then read of the frequency register
        @(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: 8'hcb, wdata: 8'h06};
        @(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: 8'hcb, wdata: 8'h00};
        @(posedge clk) req <= '0;
        #1 cmp8(rdata, 8'h06);
        // Write and read in one cycle: read returns the old code
        @(posedge clk) req <= '{wr: 1'b1, rd: 1'b1, addr: 8'hcb, wdata: 8'h00};
        @(posedge clk) req <= '0;
        #1 cmp8(rdata, 8'h06);
        reg_rd(8'hcb, d);
        cmp8(d, 8'h00);
        // Zones only, ramps idle at zero
        @(posedge clk) zd <= {8'h40, 8'h30, 8'h20, 8'h10};
        walk_binds({4{8'h00}});
        // cpu1 and reg1 hot: ramps climb to full, others stay off
        @(posedge clk) hot <= 4'h5;
        repeat (1100) @(posedge clk);
        walk_binds({8'h00, 8'hff, 8'h00, 8'hff});
        // Swap hot pins: full ramps fall, idle ones climb
        @(posedge clk) hot <= 4'ha;
        repeat (1100) @(posedge clk);
        walk_binds({8'hff, 8'h00, 8'hff, 8'h00});
        // PWM timing at code 0: 8 cycles a step, 256 steps
        @(posedge clk) hot <= 4'h0;
        zd <= {8'h40, 8'h30, 8'h20, 8'hc0};
        duty_a <= 8'h80;
        reg_wr(8'hcc, 8'h01);
        reg_wr(8'hcb, 8'hf8);
        repeat (7000) @(posedge clk);
        #1 cmp32(per_a, 32'd2048);
        cmp32(hi_a, 32'd1024);
        cmp32(per_b, 32'd2048);
        cmp32(hi_b, 32'd1536);
        // Slow codes: at duty 01 the high run is one step, 50 MHz / (f * 256)
        @(posedge clk) duty_a <= 8'h01;
        zd <= {8'h40, 8'h30, 8'h20, 8'h01};
        // Second rise surely carries duty 01; code lands before the step ends
        @(posedge out_a);
        @(posedge out_a);
        reg_wr(8'hcb, 8'h07);
        @(negedge out_a);
        repeat (2) @(posedge clk);
        #1 cmp32(wid_a, 32'd16276);
        @(posedge out_b);
        @(posedge out_b);
        @(posedge clk) freq_b <= 3'h2;
        @(negedge out_b);
        repeat (2) @(posedge clk);
        #1 cmp32(wid_b, 32'd2325);
        // Mid-run reset: defaults return, zones 1 to 4 bound again
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1 cmp8(rdata, 8'h00);
        cmp8(duty_b, 8'h00);
        cmp8({6'h00, out_a, out_b}, 8'h00);
        @(posedge clk) rst <= 1'b0;
        reg_rd(8'hcb, d);
        cmp8(d, 8'h00);
        reg_rd(8'hcc, d);
        cmp8(d, 8'h0f);
        cmp8(duty_b, 8'h40);
        print_verdict();
    end
endmodule
